// ===== verilog/poe_output_encoder.sv
// protection output encoder: pin encoding and detection delays
`timescale 1ns/1ps
module poe_output_encoder
    import poe_pkg::*;
#(
    parameter int MON_CLKS  = MON_CYCLE_CLKS,
    parameter int TEST_CLKS = TEST_CYCLE_CLKS,
    parameter int US_TICK   = US_CLKS
)
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          ce,
    // protection state from the state machine
    input  wire poe_state_type protState,
    // pin configuration
    input  wire logic          chargeActiveLow,
    input  wire poe_drive_type chargeStyle,
    input  wire logic          dischargeActiveLow,
    input  wire poe_drive_type dischargeStyle,
    input  wire logic          failActiveLow,
    input  wire poe_drive_type failStyle,
    // product-code delay selects
    input  wire logic [2:0]    cellDelaySel,
    input  wire logic [2:0]    sovDelaySel,
    input  wire logic [2:0]    openDetSel,
    input  wire logic [2:0]    openRelSel,
    input  wire logic [2:0]    docDelaySel,
    input  wire logic [2:0]    cocDelaySel,
    input  wire logic [2:0]    shortDelaySel,
    // comparator conditions and test strap (asynchronous)
    input  wire logic          ovCond,
    input  wire logic          uvCond,
    input  wire logic          sovCond,
    input  wire logic          openDetCond,
    input  wire logic          openRelCond,
    input  wire logic          tempDetCond,
    input  wire logic          tempRelCond,
    input  wire logic          docCond,
    input  wire logic          cocCond,
    input  wire logic          shortCond,
    input  wire logic          internalRegulatorLevel,
    // delay results to the state machine
    output logic               ovDone,
    output logic               uvDone,
    output logic               sovDone,
    output logic               openDetDone,
    output logic               openRelDone,
    output logic               tempDetDone,
    output logic               tempRelDone,
    output logic               docDone,
    output logic               chargeOvercurrentDelayDone,
    output logic               shortCircuitDelayDone,
    output logic               monTick,
    // pins
    output logic               chargeEnableOut,
    output logic               chargeEnableOe,
    output logic               dischargeEnableOut,
    output logic               dischargeEnableOe,
    output logic               permanentFailOut,
    output logic               permanentFailOe
);

    initial begin
        if (MON_CLKS < 2 || TEST_CLKS < 2 || US_TICK < 1)
            $error("monitor or microsecond period out of range");
        if (TEST_CLKS > MON_CLKS)
            $error("test cycle longer than monitor cycle");
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [NUM_DLY-1:0] condMeta_ff;
    logic [NUM_DLY-1:0] condSync_ff;
    logic               testMeta_ff;
    logic               testSync_ff;
    logic [NUM_DLY-1:0] condRaw;

    assign condRaw[DLY_OV]    = ovCond;
    assign condRaw[DLY_UV]    = uvCond;
    assign condRaw[DLY_SOV]   = sovCond;
    assign condRaw[DLY_OWDET] = openDetCond;
    assign condRaw[DLY_OWREL] = openRelCond;
    assign condRaw[DLY_TDET]  = tempDetCond;
    assign condRaw[DLY_TREL]  = tempRelCond;
    assign condRaw[DLY_DOC]   = docCond;
    assign condRaw[DLY_COC]   = cocCond;
    assign condRaw[DLY_SHORT] = shortCond;

    always_ff @(posedge clk) begin
        if (reset) begin
            condMeta_ff <= '0;
            condSync_ff <= '0;
            testMeta_ff <= 1'b0;
            testSync_ff <= 1'b0;
        end else if (ce) begin
            condMeta_ff <= condRaw;
            condSync_ff <= condMeta_ff;
            testMeta_ff <= internalRegulatorLevel;
            testSync_ff <= testMeta_ff;
        end
    end

    // ****************************************
    // monitoring cycle and microsecond ticks
    // ****************************************
    logic [31:0] monCount_ff;
    logic [31:0] usCount_ff;
    logic [31:0] monPeriod;
    logic        monEnd;
    logic        usTick;

    // test strap shortens the monitoring cycle
    assign monPeriod = testSync_ff ? 32'(TEST_CLKS) : 32'(MON_CLKS);
    assign monEnd    = (monCount_ff >= monPeriod - 32'h0000_0001);
    assign usTick    = (usCount_ff >= 32'(US_TICK) - 32'h0000_0001);

    always_ff @(posedge clk) begin
        if (reset) begin
            monCount_ff <= '0;
            usCount_ff  <= '0;
        end else if (ce) begin
            monCount_ff <= monEnd ? '0 : monCount_ff + 32'h0000_0001;
            usCount_ff  <= usTick ? '0 : usCount_ff + 32'h0000_0001;
        end
    end

    assign monTick = monEnd && ce;

    // ****************************************
    // delay targets
    // ****************************************
    logic [DLY_W-1:0] target [NUM_DLY];
    logic [DLY_W-1:0] cycOne;
    logic [NUM_DLY-1:0] doneVec;

    assign cycOne = DLY_W'(1);

    // test mode brings every cycle delay down to one cycle
    assign target[DLY_OV]    = testSync_ff ? cycOne
                               : poe_cell_cycles(cellDelaySel);
    assign target[DLY_UV]    = testSync_ff ? cycOne
                               : poe_cell_cycles(cellDelaySel);
    assign target[DLY_SOV]   = testSync_ff ? cycOne
                               : poe_sov_cycles(sovDelaySel);
    assign target[DLY_OWDET] = testSync_ff ? cycOne
                               : poe_cell_cycles(openDetSel);
    assign target[DLY_OWREL] = testSync_ff ? cycOne
                               : poe_cell_cycles(openRelSel);
    // fixed; no select reaches these two
    assign target[DLY_TDET]  = testSync_ff ? cycOne
                               : DLY_W'(TEMP_DELAY_CYCLES);
    assign target[DLY_TREL]  = testSync_ff ? cycOne
                               : DLY_W'(TEMP_DELAY_CYCLES);
    assign target[DLY_DOC]   = poe_oc_us(docDelaySel);
    assign target[DLY_COC]   = poe_oc_us(cocDelaySel);
    assign target[DLY_SHORT] = poe_short_us(shortDelaySel);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DLY; gi++) begin : g_dly
            logic unitTick;
            // current delays run on microseconds, the rest on cycles
            assign unitTick = (gi >= DLY_DOC) ? usTick : monEnd;
            poe_delay_counter #(
                .W      (DLY_W)
            ) u_cnt (
                .clk    (clk),
                .reset  (reset),
                .ce     (ce),
                .tick   (unitTick),
                .cond   (condSync_ff[gi]),
                .target (target[gi]),
                .done   (doneVec[gi])
            );
        end
    endgenerate

    assign ovDone                     = doneVec[DLY_OV];
    assign uvDone                     = doneVec[DLY_UV];
    assign sovDone                    = doneVec[DLY_SOV];
    assign openDetDone                = doneVec[DLY_OWDET];
    assign openRelDone                = doneVec[DLY_OWREL];
    assign tempDetDone                = doneVec[DLY_TDET];
    assign tempRelDone                = doneVec[DLY_TREL];
    assign docDone                    = doneVec[DLY_DOC];
    assign chargeOvercurrentDelayDone = doneVec[DLY_COC];
    assign shortCircuitDelayDone      = doneVec[DLY_SHORT];

    // ****************************************
    // state to pin encoding
    // ****************************************
    logic chargeAssert;
    logic chargePchHold;
    logic dischargeAssert;
    logic failAssert;

    assign chargeAssert    = (protState == ST_INIT)
                          || (protState == ST_NORMAL)
                          || (protState == ST_UV) || (protState == ST_DOC)
                          || (protState == ST_SHORT);
    // active-high p-channel keeps driving high in these states
    assign chargePchHold   = !chargeActiveLow
                          && ((protState == ST_COC) || (protState == ST_HTCI)
                          || (protState == ST_HTDI)
                          || (protState == ST_LTCI));
    assign dischargeAssert = (protState == ST_NORMAL) || (protState == ST_OV)
                          || (protState == ST_SOV) || (protState == ST_COC)
                          || (protState == ST_HTCI)
                          || (protState == ST_LTCI);
    assign failAssert      = (protState == ST_SOV);

    poe_pin_driver u_charge (
        .clk         (clk),
        .reset       (reset),
        .ce          (ce),
        .assertReq   (chargeAssert),
        .activeLow   (chargeActiveLow),
        .style       (chargeStyle),
        .pchHoldHigh (chargePchHold),
        .pinOut      (chargeEnableOut),
        .pinOe       (chargeEnableOe)
    );

    poe_pin_driver u_discharge (
        .clk         (clk),
        .reset       (reset),
        .ce          (ce),
        .assertReq   (dischargeAssert),
        .activeLow   (dischargeActiveLow),
        .style       (dischargeStyle),
        .pchHoldHigh (1'b0),
        .pinOut      (dischargeEnableOut),
        .pinOe       (dischargeEnableOe)
    );

    poe_pin_driver u_fail (
        .clk         (clk),
        .reset       (reset),
        .ce          (ce),
        .assertReq   (failAssert),
        .activeLow   (failActiveLow),
        .style       (failStyle),
        .pchHoldHigh (1'b0),
        .pinOut      (permanentFailOut),
        .pinOe       (permanentFailOe)
    );

    // ****************************************
    // checks
    // ****************************************
    chk_charge_pp_high: assert property (
        @(posedge clk) disable iff (reset)
        (ce && chargeStyle == DRV_PUSH_PULL && !chargeActiveLow
            && protState == ST_NORMAL)
            |=> chargeEnableOe && chargeEnableOut)
        else $error("charge pin not high in normal state");

    chk_charge_ov_low: assert property (
        @(posedge clk) disable iff (reset)
        (ce && chargeStyle == DRV_PUSH_PULL && !chargeActiveLow
            && protState == ST_OV)
            |=> chargeEnableOe && !chargeEnableOut)
        else $error("charge pin not low in overvoltage");

    chk_charge_nch_low: assert property (
        @(posedge clk) disable iff (reset)
        (ce && chargeStyle == DRV_NCH_OD && chargeActiveLow
            && protState == ST_UV)
            |=> chargeEnableOe && !chargeEnableOut)
        else $error("active-low n-channel charge pin not pulled low");

    chk_charge_pch_hold: assert property (
        @(posedge clk) disable iff (reset)
        (ce && chargeStyle == DRV_PCH_OD && !chargeActiveLow
            && (protState == ST_COC || protState == ST_HTDI))
            |=> chargeEnableOe && chargeEnableOut)
        else $error("p-channel charge pin not held high");

    chk_discharge_init_off: assert property (
        @(posedge clk) disable iff (reset)
        (ce && dischargeStyle == DRV_PUSH_PULL && !dischargeActiveLow
            && protState == ST_INIT)
            |=> dischargeEnableOe && !dischargeEnableOut)
        else $error("discharge pin enabled in initial state");

    chk_discharge_inverted: assert property (
        @(posedge clk) disable iff (reset)
        (ce && dischargeStyle == DRV_PUSH_PULL && dischargeActiveLow
            && protState == ST_COC)
            |=> dischargeEnableOe && !dischargeEnableOut)
        else $error("active-low discharge pin not low when asserted");

    chk_fail_only_sov: assert property (
        @(posedge clk) disable iff (reset)
        (ce && failStyle == DRV_PUSH_PULL && !failActiveLow)
            |=> permanentFailOut == ($past(protState) == ST_SOV))
        else $error("failure pin does not follow second overvoltage");

    chk_fail_low_float: assert property (
        @(posedge clk) disable iff (reset)
        (ce && failStyle == DRV_PCH_OD && failActiveLow
            && protState == ST_SOV) |=> !permanentFailOe)
        else $error("active-low p-channel failure pin driven");

    chk_test_one_cycle: assert property (
        @(posedge clk) disable iff (reset)
        testSync_ff |-> target[DLY_OV] == cycOne
            && target[DLY_SOV] == cycOne)
        else $error("test mode did not shorten cycle delays");

    chk_cell_range: assert property (
        @(posedge clk) disable iff (reset)
        !testSync_ff |-> target[DLY_OV] >= DLY_W'(2)
            && target[DLY_OV] <= DLY_W'(14) && !target[DLY_OV][0])
        else $error("cell delay outside its seven settings");

    chk_mon_period: assert property (
        @(posedge clk) disable iff (reset)
        monCount_ff < 32'(MON_CLKS))
        else $error("monitoring cycle counter overran its period");

endmodule

// ===== verilog/poe_pkg.sv
// constants, types and delay tables of the protection output encoder
//
// What this block does
// - active-high: drive high, float, or high
// - active-low: drive low, low, or float
// - charge enable asserted only in safe states
// - pch charge pin drives high under charge overcurrent
// - pch charge pin high in inhibit states
// - discharge enable asserted in listed states only
// - active-low discharge uses inverted encoding
// - failure pin asserted only at second overvoltage
// - active-low failure pin uses inverted encoding
// - cell delay seven settings, 1-2 to 13-14
// - second overvoltage delay five cycle settings
// - open-wire delays share the cell settings
// - cycle delays counted in 400 ms cycles
// - temperature delays fixed, not code selectable
// - discharge overcurrent delay 25 to 500 ms
// - charge overcurrent delay same seven values
// - short circuit delay 0.1 to 0.5 ms
// - test input shortens cycle, one-cycle delays
package poe_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ           = 250;
    localparam int US_PER_MS         = 1000;
    localparam int MON_CYCLE_MS      = 400;
    localparam int TEST_CYCLE_MS     = 100;
    localparam int US_CLKS           = CLK_MHZ;
    localparam int MON_CYCLE_CLKS    = MON_CYCLE_MS * US_PER_MS * CLK_MHZ;
    localparam int TEST_CYCLE_CLKS   = TEST_CYCLE_MS * US_PER_MS * CLK_MHZ;
    localparam int TEMP_DELAY_CYCLES = 2;
    localparam int DLY_W             = 20;

    // ****************************************
    // delay settings
    // ****************************************
    localparam int CELL_SEL_MAX        = 6;
    localparam int SOV_SEL_MAX         = 4;
    localparam int OC_SEL_MAX          = 6;
    localparam int SHORT_SEL_MAX       = 4;
    localparam int SOV_DELAY_CYC [5]   = '{6, 11, 21, 31, 41};
    localparam int OC_DELAY_MS [7]     = '{25, 50, 100, 200, 300, 400, 500};
    localparam int SHORT_DELAY_US [5]  = '{100, 200, 300, 400, 500};

    // ****************************************
    // delay counter slots
    // ****************************************
    localparam int NUM_DLY   = 10;
    localparam int DLY_OV    = 0;
    localparam int DLY_UV    = 1;
    localparam int DLY_SOV   = 2;
    localparam int DLY_OWDET = 3;
    localparam int DLY_OWREL = 4;
    localparam int DLY_TDET  = 5;
    localparam int DLY_TREL  = 6;
    localparam int DLY_DOC   = 7;
    localparam int DLY_COC   = 8;
    localparam int DLY_SHORT = 9;

    typedef enum logic [1:0] {
        DRV_PUSH_PULL,
        DRV_NCH_OD,
        DRV_PCH_OD
    } poe_drive_type;

    typedef enum logic [3:0] {
        ST_INIT,
        ST_NORMAL,
        ST_OV,
        ST_SOV,
        ST_UV,
        ST_PDOWN,
        ST_OPENW,
        ST_DOC,
        ST_COC,
        ST_SHORT,
        ST_HTCI,
        ST_HTDI,
        ST_LTCI
    } poe_state_type;

    // upper end of the 1-2 .. 13-14 cycle window
    function automatic logic [DLY_W-1:0] poe_cell_cycles(
        input logic [2:0] sel
    );
        int s;
        s = (int'(sel) > CELL_SEL_MAX) ? CELL_SEL_MAX : int'(sel);
        return DLY_W'(2 * s + 2);
    endfunction

    function automatic logic [DLY_W-1:0] poe_sov_cycles(
        input logic [2:0] sel
    );
        int s;
        s = (int'(sel) > SOV_SEL_MAX) ? SOV_SEL_MAX : int'(sel);
        return DLY_W'(SOV_DELAY_CYC[s]);
    endfunction

    function automatic logic [DLY_W-1:0] poe_oc_us(
        input logic [2:0] sel
    );
        int s;
        s = (int'(sel) > OC_SEL_MAX) ? OC_SEL_MAX : int'(sel);
        return DLY_W'(OC_DELAY_MS[s] * US_PER_MS);
    endfunction

    function automatic logic [DLY_W-1:0] poe_short_us(
        input logic [2:0] sel
    );
        int s;
        s = (int'(sel) > SHORT_SEL_MAX) ? SHORT_SEL_MAX : int'(sel);
        return DLY_W'(SHORT_DELAY_US[s]);
    endfunction

endpackage

// ===== verilog/poe_pin_driver.sv
// one output pin: polarity and driver style to level and enable
`timescale 1ns/1ps
module poe_pin_driver
    import poe_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          ce,
    // request
    input  wire logic          assertReq,
    input  wire logic          activeLow,
    input  wire poe_drive_type style,
    input  wire logic          pchHoldHigh,
    // pin
    output logic               pinOut,
    output logic               pinOe
);

    logic pinOut_ff;
    logic pinOe_ff;
    logic level;
    logic nxt_pinOut;
    logic nxt_pinOe;

    assign level = assertReq ^ activeLow;

    always_comb begin
        nxt_pinOut = 1'b0;
        nxt_pinOe  = 1'b0;
        case (style)
            DRV_PUSH_PULL: begin
                nxt_pinOut = level;
                nxt_pinOe  = 1'b1;
            end
            DRV_NCH_OD: begin
                nxt_pinOut = 1'b0;
                nxt_pinOe  = ~level;
            end
            DRV_PCH_OD: begin
                nxt_pinOut = 1'b1;
                nxt_pinOe  = level | pchHoldHigh;
            end
            default: begin
                nxt_pinOut = 1'b0;
                nxt_pinOe  = 1'b0;
            end
        endcase
    end

    // reset leaves the pin released until the state is known
    always_ff @(posedge clk) begin
        if (reset) begin
            pinOut_ff <= 1'b0;
            pinOe_ff  <= 1'b0;
        end else if (ce) begin
            pinOut_ff <= nxt_pinOut;
            pinOe_ff  <= nxt_pinOe;
        end
    end

    assign pinOut = pinOut_ff;
    assign pinOe  = pinOe_ff;

    chk_nch_float_high: assert property (
        @(posedge clk) disable iff (reset)
        (ce && style == DRV_NCH_OD && assertReq && !activeLow)
            |=> !pinOe)
        else $error("n-channel asserted active-high pin is driven");

    chk_pch_float_low: assert property (
        @(posedge clk) disable iff (reset)
        (ce && style == DRV_PCH_OD && assertReq && activeLow
            && !pchHoldHigh) |=> !pinOe)
        else $error("p-channel asserted active-low pin is driven");

endmodule

// ===== verilog/poe_delay_counter.sv
// detection delay counter in units of an external tick
`timescale 1ns/1ps
module poe_delay_counter
    import poe_pkg::*;
#(
    parameter int W = DLY_W
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         ce,
    // count
    input  wire logic         tick,
    input  wire logic         cond,
    input  wire logic [W-1:0] target,
    // result
    output logic              done
);

    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;
    logic         done_ff;
    logic         reached;

    initial begin
        if (W < 2) $error("delay counter width too small");
    end

    assign reached   = (count_ff >= target) && (target != '0);
    assign nxt_count = !cond ? '0 :
                       (tick && !reached) ? count_ff + W'(1) : count_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            count_ff <= '0;
            done_ff  <= 1'b0;
        end else if (ce) begin
            count_ff <= nxt_count;
            done_ff  <= cond && reached;
        end
    end

    assign done = done_ff;

    chk_restart_on_clear: assert property (
        @(posedge clk) disable iff (reset)
        (ce && !cond) |=> (count_ff == '0) && !done)
        else $error("delay counter kept state after condition cleared");

    chk_done_needs_count: assert property (
        @(posedge clk) disable iff (reset)
        $rose(done) |-> $past(count_ff) >= $past(target))
        else $error("delay completed before target reached");

endmodule

// ===== sim/poe_switch_model.sv
// far-side model: gate of a power switch or fuse stage seen at one pin
`timescale 1ns/1ps
module poe_switch_model (
    // pin from the encoder
    input  wire logic clk,
    input  wire logic pinOut,
    input  wire logic pinOe,
    // resolved gate level
    output logic      gateLevel
);
    // no pull resistor on the gate: undriven means a wandering level
    always_ff @(posedge clk) begin
        gateLevel <= pinOe ? pinOut : ~gateLevel;
    end
endmodule

// ===== sim/poe_output_encoder_tb.sv
// self-checking bench of the protection output encoder
`timescale 1ns/1ps
module poe_output_encoder_tb
    import poe_pkg::*;
;
    // ****************************************
    // stimulus and observation
    // ****************************************
    logic          clk = 1'b0;
    logic          reset = 1'b1;
    poe_state_type st = ST_INIT;
    poe_drive_type sty = DRV_PUSH_PULL;
    logic          al = 1'b0;
    logic          strap = 1'b0;
    logic [2:0]    sel = 3'h0;
    logic [9:0]    cnd = 10'h000;
    wire  [9:0]    dn;
    wire  [5:0]    pin;
    wire  [2:0]    gate;
    wire           mt;
    logic [1:0]    e;
    int            errors = 0;
    int            checked = 0;
    // state masks, bit index = protection state code
    localparam logic [12:0] CHARGE_ON = 13'h0293;
    localparam logic [12:0] DIS_ON    = 13'h150E;
    localparam logic [12:0] FLT_ON    = 13'h0008;
    localparam logic [12:0] HOLD_ST   = 13'h1D00;

    initial begin
        forever #2 clk = ~clk;
    end

    poe_output_encoder #(.MON_CLKS(8), .TEST_CLKS(4), .US_TICK(1)) i_dut (
        .clk(clk), .reset(reset), .ce(1'b1), .protState(st),
        .chargeActiveLow(al), .chargeStyle(sty), .dischargeActiveLow(al),
        .dischargeStyle(sty), .failActiveLow(al), .failStyle(sty),
        .cellDelaySel(sel), .sovDelaySel(sel), .openDetSel(sel),
        .openRelSel(sel), .docDelaySel(sel), .cocDelaySel(sel),
        .shortDelaySel(sel), .ovCond(cnd[0]), .uvCond(cnd[1]),
        .sovCond(cnd[2]), .openDetCond(cnd[3]), .openRelCond(cnd[4]),
        .tempDetCond(cnd[5]), .tempRelCond(cnd[6]), .docCond(cnd[7]),
        .cocCond(cnd[8]), .shortCond(cnd[9]),
        .internalRegulatorLevel(strap), .ovDone(dn[0]), .uvDone(dn[1]),
        .sovDone(dn[2]), .openDetDone(dn[3]), .openRelDone(dn[4]),
        .tempDetDone(dn[5]), .tempRelDone(dn[6]), .docDone(dn[7]),
        .chargeOvercurrentDelayDone(dn[8]),
        .shortCircuitDelayDone(dn[9]), .monTick(mt),
        .chargeEnableOut(pin[5]), .chargeEnableOe(pin[4]),
        .dischargeEnableOut(pin[3]), .dischargeEnableOe(pin[2]),
        .permanentFailOut(pin[1]), .permanentFailOe(pin[0]));

    for (genvar g = 0; g < 3; g++) begin : g_sw
        poe_switch_model i_sw (.clk(clk), .pinOut(pin[2*g+1]),
                               .pinOe(pin[2*g]), .gateLevel(gate[g]));
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %b expected %b", $time, seen, exp);
        end
    endtask

    function automatic logic [1:0] enc(input logic a, input logic lo,
                                       input int y, input logic h);
        logic v;
        v = a ^ lo;
        case (y)
            0: return {v, 1'b1};
            1: return {1'b0, ~v};
            default: return {1'b1, v | h};
        endcase
    endfunction

    // onset to done must land inside the (tgt-1)..tgt unit window
    task automatic meas(input int idx, input logic [2:0] s, input int tgt,
                        input int unit);
        int n;
        sel = s;
        cnd[idx] = 1'b1;
        n = 0;
        while (dn[idx] !== 1'b1 && n < 30000) begin
            @(negedge clk);
            n++;
        end
        check(2'(n >= (tgt - 1) * unit && n <= tgt * unit + 6), 2'b01);
        cnd[idx] = 1'b0;
        repeat (4) @(negedge clk);
        check({1'b0, dn[idx]}, 2'b00);
    endtask

    // the cycle tick must pulse once per monitoring period
    task automatic ticks(input int exp);
        int k;
        k = 0;
        repeat (80) begin
            @(negedge clk);
            if (mt === 1'b1)
                k++;
        end
        check(2'(k == exp), 2'b01);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (12) @(negedge clk);
        check({pin[4], pin[2]}, 2'b00);
        reset = 1'b0;
        for (int s = 0; s < 13; s++)
            for (int y = 0; y < 3; y++)
                for (int p = 0; p < 2; p++) begin
                    st = poe_state_type'(s);
                    sty = poe_drive_type'(y);
                    al = p[0];
                    repeat (2) @(negedge clk);
                    e = enc(CHARGE_ON[s], al, y, ~al & HOLD_ST[s]);
                    check(pin[5:4], e);
                    if (e[0]) check({1'b0, gate[2]}, {1'b0, e[1]});
                    check(pin[3:2], enc(DIS_ON[s], al, y, 1'b0));
                    check(pin[1:0], enc(FLT_ON[s], al, y, 1'b0));
                end
        ticks(10);
        // bursts one clock over a cycle end before done can rise; a counter
        // that kept its count across the gaps would complete the delay
        sel = 3'h0;
        repeat (6) begin
            cnd[3] = 1'b1;
            repeat (9) @(negedge clk);
            check({1'b0, dn[3]}, 2'b00);
            cnd[3] = 1'b0;
            repeat (3) @(negedge clk);
        end
        meas(0, 3'h6, 14, 8);
        meas(1, 3'h1, 4, 8);
        meas(2, 3'h4, 41, 8);
        meas(3, 3'h0, 2, 8);
        meas(4, 3'h3, 8, 8);
        meas(5, 3'h6, TEMP_DELAY_CYCLES, 8);
        meas(6, 3'h0, TEMP_DELAY_CYCLES, 8);
        meas(7, 3'h0, 25000, 1);
        meas(8, 3'h0, 25000, 1);
        meas(9, 3'h4, 500, 1);
        strap = 1'b1;
        repeat (8) @(negedge clk);
        meas(2, 3'h4, 1, 4);
        ticks(20);
        give_verdict();
    end

    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule
